/* nasl_pkg.sv */
/*
  nasl_pkg: shared widths, reset values, operation codes and carrier types
  for the nibble alu and skip datapath.
  assumes: included before nasl_core; nothing is imported anywhere.
*/
package nasl_pkg;

  // datapath widths
  localparam int ACC_W   = 4;
  localparam int ROM_W   = 8;
  localparam int DLOW_W  = 3;
  localparam int BIT_W   = 2;
  localparam int TADDR_W = DLOW_W + ACC_W;

  // reset values
  localparam logic [3:0] ACC_RST   = 4'h0;
  localparam logic [3:0] BREG_RST  = 4'h0;
  localparam logic       CARRY_RST = 1'b0;

  // table read field positions within a rom word
  localparam int ROM_HI_LSB = 4;
  localparam int ROM_LO_LSB = 0;

  // table read occupies this many cycles from issue to load
  localparam int TABLE_CYCLES = 2;

  // decoded operations handed to the datapath
  typedef enum logic [4:0] {
    NASL_OP_NONE,
    NASL_OP_LOAD_IMMEDIATE_ACC,
    NASL_OP_TABLE_READ_PAIR,
    NASL_OP_ADD_MEMORY,
    NASL_OP_ADD_MEMORY_CARRY,
    NASL_OP_ADD_IMMEDIATE,
    NASL_OP_AND_MEMORY,
    NASL_OP_OR_MEMORY,
    NASL_OP_SET_CARRY,
    NASL_OP_CLEAR_CARRY,
    NASL_OP_SKIP_IF_CARRY_CLEAR,
    NASL_OP_COMPLEMENT_ACC,
    NASL_OP_ROTATE_RIGHT_CARRY,
    NASL_OP_SET_MEM_BIT,
    NASL_OP_CLEAR_MEM_BIT,
    NASL_OP_SKIP_IF_MEM_BIT_CLEAR,
    NASL_OP_SKIP_IF_ACC_EQ_MEM,
    NASL_OP_SKIP_IF_ACC_EQ_IMM
  } nasl_op_t;

  // one issued instruction
  typedef struct packed {
    nasl_op_t           op;
    logic [ACC_W-1:0]   imm;
    logic [BIT_W-1:0]   bit_sel;
  } nasl_instr_t;

endpackage : nasl_pkg

/* nasl_core.sv */
/*
  nasl_core: execution datapath of a 4-bit cpu core: accumulator, register
  b, carry_bit, skip status, load-run suppression, table read and memory
  bit writes.
  assumes: a sequencer issues one decoded instruction per cycle that i_valid is high,
  presents pointed_ram_nibble on i_mem_data in that cycle, returns the rom
  word in the cycle that o_rom_req is high, and keeps the return stack.
*/
// Contract
// - load_immediate_acc writes immediate into accumulator, carry_bit untouched.
// - back-to-back load_immediate_acc run: only first executes, rest skipped.
// - table_read_pair reads rom {page,d[2:0],acc}; bits 7-4 to b, 3-0 to acc.
// - table_read_pair uses one return stack level while executing.
// - add_memory adds pointed_ram_nibble to accumulator; carry_bit unchanged.
// - add_memory_carry adds nibble and carry_bit; carry out into carry_bit.
// - add immediate keeps carry_bit; skips next when no overflow.
// - and replaces accumulator with acc and pointed_ram_nibble, carry kept.
// - or replaces accumulator with acc or pointed_ram_nibble, carry kept.
// - set_carry forces one, clear_carry forces zero; accumulator kept.
// - carry test skips next instruction when carry_bit is zero.
// - complement_acc inverts all four accumulator bits.
// - rotate_right_carry shifts carry and accumulator right; old a0 to carry.
// - set_mem_bit and clear_mem_bit force bit j of nibble, others intact.
// - skip_if_mem_bit_clear skips next when bit j of nibble is zero.
// - skip_if_acc_eq_mem skips next when accumulator equals nibble.
// - skip_if_acc_eq_imm skips next when accumulator equals immediate.
`timescale 1ns/10ps
module nasl_core #(
  parameter int PAGE_W = 5
) (
  // clock, reset, enable
  input  wire logic                             i_clk,
  input  wire logic                             i_rst,
  input  wire logic                             i_ce,
  // instruction issue
  input  wire logic                             i_valid,
  input  wire nasl_pkg::nasl_instr_t            i_instr,
  input  wire logic [PAGE_W-1:0]                i_page,
  input  wire logic [nasl_pkg::DLOW_W-1:0]      i_d_low,
  // pointed ram nibble and rom word
  input  wire logic [nasl_pkg::ACC_W-1:0]       i_mem_data,
  input  wire logic [nasl_pkg::ROM_W-1:0]       i_rom_data,
  // architectural state
  output logic [nasl_pkg::ACC_W-1:0]            o_acc,
  output logic [nasl_pkg::ACC_W-1:0]            o_b,
  output logic                                  o_carry,
  output logic                                  o_skip,
  output logic                                  o_busy,
  // memory write-back
  output logic                                  o_mem_wr,
  output logic [nasl_pkg::ACC_W-1:0]            o_mem_wdata,
  // table read rom port and stack
  output logic                                  o_rom_req,
  output logic [PAGE_W+nasl_pkg::TADDR_W-1:0]   o_rom_addr,
  output logic                                  o_stack_push,
  output logic                                  o_stack_pop
);

  localparam int RA_W = PAGE_W + nasl_pkg::TADDR_W;

  // refuse page widths the rom address cannot carry
  if (PAGE_W < 1 || PAGE_W > 8) begin : g_page_check
    $error("nasl_core: PAGE_W must be 1 to 8");
  end

  typedef struct packed {
    logic [nasl_pkg::ACC_W-1:0] acc;
    logic [nasl_pkg::ACC_W-1:0] b;
    logic                       carry;
    logic                       skip;
    logic                       li_run;
    logic                       busy;
    logic                       mem_wr;
    logic [nasl_pkg::ACC_W-1:0] mem_wdata;
    logic                       rom_req;
    logic [RA_W-1:0]            rom_addr;
    logic                       push;
    logic                       pop;
  } nasl_state_t;

  nasl_state_t q;
  nasl_state_t next_q;

  // helper terms for the current instruction
  logic                       take;
  logic                       exec;
  logic                       is_li;
  logic [nasl_pkg::ACC_W:0]   sum_mem;
  logic [nasl_pkg::ACC_W:0]   sum_memc;
  logic [nasl_pkg::ACC_W:0]   sum_imm;
  logic                       mem_bit;

  assign take     = i_valid && !q.busy;
  assign is_li    = i_instr.op == nasl_pkg::NASL_OP_LOAD_IMMEDIATE_ACC;
  // skipped by a test or by a load run
  assign exec     = take && !q.skip && !(is_li && q.li_run);
  assign sum_mem  = {1'b0, q.acc} + {1'b0, i_mem_data};
  assign sum_memc = {1'b0, q.acc} + {1'b0, i_mem_data} + {4'h0, q.carry};
  assign sum_imm  = {1'b0, q.acc} + {1'b0, i_instr.imm};
  assign mem_bit  = i_mem_data[i_instr.bit_sel];

  // next state of the datapath
  always_comb begin
    next_q         = q;
    next_q.mem_wr  = 1'b0;
    next_q.rom_req = 1'b0;
    next_q.push    = 1'b0;
    next_q.pop     = 1'b0;
    if (q.busy) begin
      // rom word arrives: load pair, release stack level
      next_q.b    = i_rom_data[nasl_pkg::ROM_HI_LSB +: nasl_pkg::ACC_W];
      next_q.acc  = i_rom_data[nasl_pkg::ROM_LO_LSB +: nasl_pkg::ACC_W];
      next_q.pop  = 1'b1;
      next_q.busy = 1'b0;
    end else if (take) begin
      next_q.skip   = 1'b0;
      next_q.li_run = is_li;
      if (exec) begin
        case (i_instr.op)
          nasl_pkg::NASL_OP_LOAD_IMMEDIATE_ACC: begin
            next_q.acc = i_instr.imm;
          end
          nasl_pkg::NASL_OP_TABLE_READ_PAIR: begin
            next_q.rom_req  = 1'b1;
            next_q.rom_addr = {i_page, i_d_low, q.acc};
            next_q.push     = 1'b1;
            next_q.busy     = 1'b1;
          end
          nasl_pkg::NASL_OP_ADD_MEMORY: begin
            next_q.acc = sum_mem[nasl_pkg::ACC_W-1:0];
          end
          nasl_pkg::NASL_OP_ADD_MEMORY_CARRY: begin
            next_q.acc   = sum_memc[nasl_pkg::ACC_W-1:0];
            next_q.carry = sum_memc[nasl_pkg::ACC_W];
          end
          nasl_pkg::NASL_OP_ADD_IMMEDIATE: begin
            next_q.acc  = sum_imm[nasl_pkg::ACC_W-1:0];
            next_q.skip = !sum_imm[nasl_pkg::ACC_W];
          end
          nasl_pkg::NASL_OP_AND_MEMORY: begin
            next_q.acc = q.acc & i_mem_data;
          end
          nasl_pkg::NASL_OP_OR_MEMORY: begin
            next_q.acc = q.acc | i_mem_data;
          end
          nasl_pkg::NASL_OP_SET_CARRY: begin
            next_q.carry = 1'b1;
          end
          nasl_pkg::NASL_OP_CLEAR_CARRY: begin
            next_q.carry = 1'b0;
          end
          nasl_pkg::NASL_OP_SKIP_IF_CARRY_CLEAR: begin
            next_q.skip = !q.carry;
          end
          nasl_pkg::NASL_OP_COMPLEMENT_ACC: begin
            next_q.acc = ~q.acc;
          end
          nasl_pkg::NASL_OP_ROTATE_RIGHT_CARRY: begin
            {next_q.acc, next_q.carry} = {q.carry, q.acc};
          end
          nasl_pkg::NASL_OP_SET_MEM_BIT: begin
            next_q.mem_wr    = 1'b1;
            next_q.mem_wdata = i_mem_data | (4'h1 << i_instr.bit_sel);
          end
          nasl_pkg::NASL_OP_CLEAR_MEM_BIT: begin
            next_q.mem_wr    = 1'b1;
            next_q.mem_wdata = i_mem_data & ~(4'h1 << i_instr.bit_sel);
          end
          nasl_pkg::NASL_OP_SKIP_IF_MEM_BIT_CLEAR: begin
            next_q.skip = !mem_bit;
          end
          nasl_pkg::NASL_OP_SKIP_IF_ACC_EQ_MEM: begin
            next_q.skip = q.acc == i_mem_data;
          end
          nasl_pkg::NASL_OP_SKIP_IF_ACC_EQ_IMM: begin
            next_q.skip = q.acc == i_instr.imm;
          end
          default: begin
            next_q.skip = 1'b0;
          end
        endcase
      end
    end
  end

  // state register, frozen while the enable is low
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q          <= '0;
      q.acc      <= nasl_pkg::ACC_RST;
      q.b        <= nasl_pkg::BREG_RST;
      q.carry    <= nasl_pkg::CARRY_RST;
    end else if (i_ce) begin
      q <= next_q;
    end
  end

  // outputs straight from the state register
  assign o_acc        = q.acc;
  assign o_b          = q.b;
  assign o_carry      = q.carry;
  assign o_skip       = q.skip;
  assign o_busy       = q.busy;
  assign o_mem_wr     = q.mem_wr;
  assign o_mem_wdata  = q.mem_wdata;
  assign o_rom_req    = q.rom_req;
  assign o_rom_addr   = q.rom_addr;
  assign o_stack_push = q.push;
  assign o_stack_pop  = q.pop;

  // checks on the datapath
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  logic step;
  assign step = i_ce && exec;

  sequence s_table_issue;
    i_ce && exec && i_instr.op == nasl_pkg::NASL_OP_TABLE_READ_PAIR;
  endsequence

  // rom request and stack level show in the cycle after issue
  sequence s_table_start;
    o_busy && o_rom_req && o_stack_push;
  endsequence

  // after one enabled cycle the pair is loaded and the level given back
  sequence s_table_load;
    !o_busy && o_stack_pop;
  endsequence

  load_imm_a: assert property (step && is_li |=> o_acc == $past(i_instr.imm) && o_carry == $past(o_carry))
    else $error("load immediate result wrong");

  load_run_a: assert property (i_ce && take && is_li && q.li_run && !q.skip |=> $stable(o_acc))
    else $error("second load of a run changed the accumulator");

  table_start_a: assert property (s_table_issue |=> s_table_start)
    else $error("table read did not request and push");

  table_load_a: assert property (s_table_issue ##1 i_ce |=> s_table_load)
    else $error("table read did not load and pop");

  busy_refuse_a: assert property (i_ce && o_busy |=> !o_busy && !o_rom_req && !o_stack_push)
    else $error("issue accepted while table read busy");

  add_mem_a: assert property (step && i_instr.op == nasl_pkg::NASL_OP_ADD_MEMORY
    |=> o_acc == 4'($past(o_acc) + $past(i_mem_data)) && o_carry == $past(o_carry))
    else $error("add memory result wrong");

  add_carry_a: assert property (step && i_instr.op == nasl_pkg::NASL_OP_ADD_MEMORY_CARRY
    |=> {o_carry, o_acc} == $past(sum_memc))
    else $error("add with carry result wrong");

  add_imm_a: assert property (step && i_instr.op == nasl_pkg::NASL_OP_ADD_IMMEDIATE
    |=> o_skip == !$past(sum_imm[4]) && o_carry == $past(o_carry))
    else $error("add immediate skip or carry wrong");

  and_mem_a: assert property (step && i_instr.op == nasl_pkg::NASL_OP_AND_MEMORY
    |=> o_acc == ($past(o_acc) & $past(i_mem_data)) && $stable(o_carry))
    else $error("and with memory result wrong");

  or_mem_a: assert property (step && i_instr.op == nasl_pkg::NASL_OP_OR_MEMORY
    |=> o_acc == ($past(o_acc) | $past(i_mem_data)) && $stable(o_carry))
    else $error("or with memory result wrong");

  carry_force_a: assert property (step && (i_instr.op == nasl_pkg::NASL_OP_SET_CARRY
    || i_instr.op == nasl_pkg::NASL_OP_CLEAR_CARRY)
    |=> o_carry == $past(i_instr.op == nasl_pkg::NASL_OP_SET_CARRY) && $stable(o_acc))
    else $error("carry set or clear wrong");

  carry_test_a: assert property (step && i_instr.op == nasl_pkg::NASL_OP_SKIP_IF_CARRY_CLEAR
    |=> o_skip == !$past(o_carry))
    else $error("carry test skip wrong");

  complement_acc_a: assert property (step && i_instr.op == nasl_pkg::NASL_OP_COMPLEMENT_ACC
    |=> o_acc == ~$past(o_acc) && $stable(o_carry))
    else $error("complement result wrong");

  rotate_chain_a: assert property (step && i_instr.op == nasl_pkg::NASL_OP_ROTATE_RIGHT_CARRY
    |=> o_carry == $past(o_acc[0]) && o_acc == {$past(o_carry), $past(o_acc[3:1])})
    else $error("rotate through carry wrong");

  mem_bit_a: assert property (step && i_instr.op == nasl_pkg::NASL_OP_CLEAR_MEM_BIT
    |=> o_mem_wr && !o_mem_wdata[$past(i_instr.bit_sel)] && (o_mem_wdata | (4'h1 << $past(i_instr.bit_sel)))
        == ($past(i_mem_data) | (4'h1 << $past(i_instr.bit_sel))))
    else $error("bit clear disturbed the nibble");

  bit_set_a: assert property (step && i_instr.op == nasl_pkg::NASL_OP_SET_MEM_BIT
    |=> o_mem_wr && o_mem_wdata == ($past(i_mem_data) | (4'h1 << $past(i_instr.bit_sel))))
    else $error("bit set disturbed the nibble");

  bit_test_a: assert property (step && i_instr.op == nasl_pkg::NASL_OP_SKIP_IF_MEM_BIT_CLEAR
    |=> o_skip == !$past(i_mem_data[i_instr.bit_sel]) && !o_mem_wr)
    else $error("bit test skip wrong");

  compare_skip_a: assert property (step && i_instr.op == nasl_pkg::NASL_OP_SKIP_IF_ACC_EQ_MEM
    |=> o_skip == ($past(o_acc) == $past(i_mem_data)) && $stable(o_acc))
    else $error("compare with memory skip wrong");

  imm_compare_a: assert property (step && i_instr.op == nasl_pkg::NASL_OP_SKIP_IF_ACC_EQ_IMM
    |=> o_skip == ($past(o_acc) == $past(i_instr.imm)) && $stable(o_acc))
    else $error("compare with immediate skip wrong");

  skip_quiet_a: assert property (i_ce && take && q.skip
    |=> $stable(o_acc) && $stable(o_carry) && !o_mem_wr && !o_stack_push && !o_skip)
    else $error("skipped instruction had an effect");

endmodule : nasl_core

/* nasl_core_test.sv */
/*
  nasl_core_test: self-checking bench for the nibble alu and skip datapath.
  assumes: nasl_pkg is compiled first; the bench plays the sequencer.
*/
`timescale 1ns/10ps
module nasl_core_test;
  // design inputs, all driven at the falling edge
  logic                  i_clk = 1'b0;
  logic                  i_rst = 1'b1;
  logic                  i_ce = 1'b1;
  logic                  i_valid = 1'b0;
  nasl_pkg::nasl_instr_t i_instr = '0;
  logic [4:0]            i_page = 5'h0;
  logic [2:0]            i_d_low = 3'h0;
  logic [3:0]            i_mem_data = 4'h0;
  logic [7:0]            i_rom_data = 8'h0;
  // design outputs
  logic [3:0]            o_acc, o_b, o_mem_wdata;
  logic                  o_carry, o_skip, o_busy, o_mem_wr, o_rom_req, o_stack_push, o_stack_pop;
  logic [11:0]           o_rom_addr;
  int                    mismatches = 0;
  int                    total_checks = 0;

  // 100 mhz clock
  always #5 i_clk = ~i_clk;

  nasl_core #(.PAGE_W(5)) u_nasl_core (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_valid(i_valid), .i_instr(i_instr),
    .i_page(i_page), .i_d_low(i_d_low), .i_mem_data(i_mem_data), .i_rom_data(i_rom_data),
    .o_acc(o_acc), .o_b(o_b), .o_carry(o_carry), .o_skip(o_skip), .o_busy(o_busy),
    .o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata), .o_rom_req(o_rom_req),
    .o_rom_addr(o_rom_addr), .o_stack_push(o_stack_push), .o_stack_pop(o_stack_pop)
  );

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  // one compare for every value seen at the ports
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // one-cycle issue from a falling edge; results are settled on return
  // valid stays up, so back-to-back slots never lower and raise it at once
  task automatic issue(input nasl_pkg::nasl_op_t op, input logic [3:0] imm, input logic [1:0] bs,
                       input logic [3:0] mem);
    i_valid = 1'b1;
    i_instr = '{op, imm, bs};
    i_mem_data = mem;
    @(negedge i_clk);
  endtask : issue

  // issue, then judge accumulator, carry and skip status
  task automatic step(input nasl_pkg::nasl_op_t op, input logic [3:0] imm, input logic [1:0] bs,
                      input logic [3:0] mem, input logic [3:0] ea, input logic ec, input logic es);
    issue(op, imm, bs, mem);
    chk("acc", 12'(ea), 12'(o_acc));
    chk("carry", 12'(ec), 12'(o_carry));
    chk("skip", 12'(es), 12'(o_skip));
  endtask : step

  task automatic t_alu;
    step(nasl_pkg::NASL_OP_LOAD_IMMEDIATE_ACC, 4'h9, 2'h0, 4'h0, 4'h9, 1'b0, 1'b0);
    step(nasl_pkg::NASL_OP_SET_CARRY, 4'h0, 2'h0, 4'h0, 4'h9, 1'b1, 1'b0);
    step(nasl_pkg::NASL_OP_ADD_MEMORY, 4'h0, 2'h0, 4'h8, 4'h1, 1'b1, 1'b0);
    step(nasl_pkg::NASL_OP_ADD_MEMORY_CARRY, 4'h0, 2'h0, 4'he, 4'h0, 1'b1, 1'b0);
    step(nasl_pkg::NASL_OP_ADD_MEMORY_CARRY, 4'h0, 2'h0, 4'h3, 4'h4, 1'b0, 1'b0);
    step(nasl_pkg::NASL_OP_OR_MEMORY, 4'h0, 2'h0, 4'ha, 4'he, 1'b0, 1'b0);
    step(nasl_pkg::NASL_OP_AND_MEMORY, 4'h0, 2'h0, 4'h7, 4'h6, 1'b0, 1'b0);
    step(nasl_pkg::NASL_OP_COMPLEMENT_ACC, 4'h0, 2'h0, 4'h0, 4'h9, 1'b0, 1'b0);
    step(nasl_pkg::NASL_OP_SET_CARRY, 4'h0, 2'h0, 4'h0, 4'h9, 1'b1, 1'b0);
    step(nasl_pkg::NASL_OP_ROTATE_RIGHT_CARRY, 4'h0, 2'h0, 4'h0, 4'hc, 1'b1, 1'b0);
    step(nasl_pkg::NASL_OP_ROTATE_RIGHT_CARRY, 4'h0, 2'h0, 4'h0, 4'he, 1'b0, 1'b0);
    $display("alu test done");
  endtask : t_alu

  task automatic t_skip;
    step(nasl_pkg::NASL_OP_LOAD_IMMEDIATE_ACC, 4'h3, 2'h0, 4'h0, 4'h3, 1'b0, 1'b0);
    issue(nasl_pkg::NASL_OP_LOAD_IMMEDIATE_ACC, 4'h5, 2'h0, 4'h0);
    chk("acc", 12'h3, 12'(o_acc));
    step(nasl_pkg::NASL_OP_ADD_IMMEDIATE, 4'h2, 2'h0, 4'h0, 4'h5, 1'b0, 1'b1);
    step(nasl_pkg::NASL_OP_COMPLEMENT_ACC, 4'h0, 2'h0, 4'h0, 4'h5, 1'b0, 1'b0);
    step(nasl_pkg::NASL_OP_ADD_IMMEDIATE, 4'hc, 2'h0, 4'h0, 4'h1, 1'b0, 1'b0);
    step(nasl_pkg::NASL_OP_LOAD_IMMEDIATE_ACC, 4'h8, 2'h0, 4'h0, 4'h8, 1'b0, 1'b0);
    step(nasl_pkg::NASL_OP_SKIP_IF_CARRY_CLEAR, 4'h0, 2'h0, 4'h0, 4'h8, 1'b0, 1'b1);
    step(nasl_pkg::NASL_OP_SET_CARRY, 4'h0, 2'h0, 4'h0, 4'h8, 1'b0, 1'b0);
    step(nasl_pkg::NASL_OP_SET_CARRY, 4'h0, 2'h0, 4'h0, 4'h8, 1'b1, 1'b0);
    step(nasl_pkg::NASL_OP_SKIP_IF_CARRY_CLEAR, 4'h0, 2'h0, 4'h0, 4'h8, 1'b1, 1'b0);
    step(nasl_pkg::NASL_OP_SKIP_IF_ACC_EQ_MEM, 4'h0, 2'h0, 4'h8, 4'h8, 1'b1, 1'b1);
    step(nasl_pkg::NASL_OP_NONE, 4'h0, 2'h0, 4'h0, 4'h8, 1'b1, 1'b0);
    step(nasl_pkg::NASL_OP_SKIP_IF_ACC_EQ_MEM, 4'h0, 2'h0, 4'h9, 4'h8, 1'b1, 1'b0);
    step(nasl_pkg::NASL_OP_SKIP_IF_ACC_EQ_IMM, 4'h8, 2'h0, 4'h0, 4'h8, 1'b1, 1'b1);
    step(nasl_pkg::NASL_OP_LOAD_IMMEDIATE_ACC, 4'h2, 2'h0, 4'h0, 4'h8, 1'b1, 1'b0);
    step(nasl_pkg::NASL_OP_SKIP_IF_ACC_EQ_IMM, 4'h7, 2'h0, 4'h0, 4'h8, 1'b1, 1'b0);
    step(nasl_pkg::NASL_OP_ADD_IMMEDIATE, 4'hf, 2'h0, 4'h0, 4'h7, 1'b1, 1'b0);
    $display("skip test done");
  endtask : t_skip

  // every bit position for set, clear and test
  task automatic t_bits;
    logic [3:0] m;
    for (int j = 0; j < 4; j++) begin
      m = 4'h1 << j;
      step(nasl_pkg::NASL_OP_SET_MEM_BIT, 4'h0, 2'(j), 4'h0, 4'h7, 1'b1, 1'b0);
      chk("mem_wr", 12'h1, 12'(o_mem_wr));
      chk("wdata", 12'(m), 12'(o_mem_wdata));
      step(nasl_pkg::NASL_OP_CLEAR_MEM_BIT, 4'h0, 2'(j), 4'hf, 4'h7, 1'b1, 1'b0);
      chk("wdata", 12'(m ^ 4'hf), 12'(o_mem_wdata));
      step(nasl_pkg::NASL_OP_SKIP_IF_MEM_BIT_CLEAR, 4'h0, 2'(j), m, 4'h7, 1'b1, 1'b0);
      chk("mem_wr", 12'h0, 12'(o_mem_wr));
      step(nasl_pkg::NASL_OP_SKIP_IF_MEM_BIT_CLEAR, 4'h0, 2'(j), ~m, 4'h7, 1'b1, 1'b1);
      step(nasl_pkg::NASL_OP_NONE, 4'h0, 2'h0, 4'h0, 4'h7, 1'b1, 1'b0);
    end
    $display("bit test done");
  endtask : t_bits

  // table read, with an issue during busy that must be ignored
  task automatic t_table;
    step(nasl_pkg::NASL_OP_LOAD_IMMEDIATE_ACC, 4'h5, 2'h0, 4'h0, 4'h5, 1'b1, 1'b0);
    i_page = 5'h13;
    i_d_low = 3'h6;
    issue(nasl_pkg::NASL_OP_TABLE_READ_PAIR, 4'h0, 2'h0, 4'h0);
    chk("rom_req", 12'h1, 12'(o_rom_req));
    chk("rom_addr", {5'h13, 3'h6, 4'h5}, o_rom_addr);
    chk("push", 12'h1, 12'(o_stack_push));
    chk("busy", 12'h1, 12'(o_busy));
    i_rom_data = 8'ha7;
    issue(nasl_pkg::NASL_OP_COMPLEMENT_ACC, 4'h0, 2'h0, 4'h0);
    i_rom_data = 8'h58; // rom word no longer valid
    chk("b", 12'ha, 12'(o_b));
    chk("acc", 12'h7, 12'(o_acc));
    chk("pop", 12'h1, 12'(o_stack_pop));
    chk("busy", 12'h0, 12'(o_busy));
    $display("table test done");
  endtask : t_table

  // enable low freezes all state; reset wins over a low enable
  task automatic t_hold;
    i_ce = 1'b0;
    issue(nasl_pkg::NASL_OP_COMPLEMENT_ACC, 4'h0, 2'h0, 4'h0);
    chk("acc", 12'h7, 12'(o_acc));
    chk("b", 12'ha, 12'(o_b));
    i_ce = 1'b1;
    issue(nasl_pkg::NASL_OP_COMPLEMENT_ACC, 4'h0, 2'h0, 4'h0);
    chk("acc", 12'h8, 12'(o_acc));
    i_ce = 1'b0;
    i_rst = 1'b1;
    issue(nasl_pkg::NASL_OP_SET_CARRY, 4'h0, 2'h0, 4'h0);
    chk("acc", 12'h0, 12'(o_acc));
    chk("carry", 12'h0, 12'(o_carry));
    chk("b", 12'h0, 12'(o_b));
    // no request in the first cycle after release
    i_rst = 1'b0;
    i_ce = 1'b1;
    i_valid = 1'b0;
    @(negedge i_clk);
    chk("acc", 12'h0, 12'(o_acc));
    chk("skip", 12'h0, 12'(o_skip));
    $display("hold test done");
  endtask : t_hold

  // main sequence
  initial begin
    repeat (12) @(negedge i_clk);
    chk("acc", 12'h0, 12'(o_acc));
    chk("carry", 12'h0, 12'(o_carry));
    i_rst = 1'b0;
    @(negedge i_clk);
    t_alu();
    t_skip();
    t_bits();
    t_table();
    t_hold();
    stop_test();
  end

  // hang guard
  initial begin
    repeat (5000) @(posedge i_clk);
    mismatches++;
    stop_test();
  end
endmodule : nasl_core_test
